// ---- internal_flash_sram_control.sv ----
// internal sram with bit alias access and flash array with sequencer
// assumes bus requests and flash commands are synchronous to clock
// Operation
// - provides 32 KB sram and 96 KB flash to the bus masters
// - sram region decoded from base 0x2000_0000
// - alias address = alias base + 32 * byte offset + 4 * bit
// - alias access touches only the addressed bit, write is atomic
// - flash erased in 1 KB blocks, erase sets all bits to one
// - program acts on one 32-bit word, only clears bits
// - erase blocks paired into 2 KB units, each with its own protection
// - erase or program to a read-only unit is rejected
// - execute-only unit refuses data reads, allows fetches; change is set by its program-allow bit
// - flash timing derived from programmable cycles per microsecond
// - reset loads the reload suited to the highest clock rate
// - program-allow bit permits change, read-allow bit permits data reads
// - all flash accesses held off while an operation runs
`timescale 1ns/10ps
module internal_flash_sram_control (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // memory bus
  input internal_memory_pkg::mem_req_s memReq,
  output logic memReady,
  output internal_memory_pkg::mem_rsp_s memRsp,
  // flash command port
  input internal_memory_pkg::flash_cmd_s flashCmd,
  output logic flashCmdReady,
  output logic flashBusy,
  output logic flashDone,
  output logic flashViolation,
  // timing reload
  input wire logic reloadWrite,
  input wire logic [7:0] reloadValue,
  output logic [7:0] microsecondCycleReload,
  // protection, per 2 KB unit
  input wire logic [internal_memory_pkg::PROTECT_UNITS-1:0] blockProgramAllowMask,
  input wire logic [internal_memory_pkg::PROTECT_UNITS-1:0] blockReadAllowMask
);
  import internal_memory_pkg::*;

  typedef struct packed {
    flash_state_e state;
    flash_op_e op;
    logic [14:0] ptr;
    logic [14:0] last;
    logic [31:0] data;
    logic [15:0] usLeft;
    logic busy;
    logic done;
    logic violation;
    mem_rsp_s rsp;
  } ctrl_state_s;

  localparam logic [31:0] FLASH_END = FLASH_BASE + 32'(FLASH_BYTES);
  localparam logic [31:0] SRAM_END = SRAM_BASE + 32'(SRAM_BYTES);
  localparam logic [31:0] ALIAS_END = ALIAS_BASE + 32'(SRAM_BYTES * ALIAS_FACTOR);

  logic [31:0] sram [SRAM_WORDS];
  logic [31:0] flash [FLASH_WORDS];

  ctrl_state_s s, next_s;
  logic usTick;
  logic inFlash, inSram, inAlias, accept, readAllowed, cmdInRange, cmdAllowed;
  logic sramWe, aliasWe, flashWe;
  logic [14:0] flashWord, cmdWord;
  logic [12:0] sramWord, aliasWord;
  logic [4:0] aliasBit;
  logic [5:0] cmdUnit;
  logic [31:0] flashWrData;

  microsecond_tick tickGen (
    .clock(clock),
    .rst(rst),
    .reloadWrite(reloadWrite),
    .reloadValue(reloadValue),
    .microsecondCycleReload(microsecondCycleReload),
    .usTick(usTick)
  );

  // address decode
  assign inFlash = memReq.addr < FLASH_END;
  assign inSram = memReq.addr >= SRAM_BASE && memReq.addr < SRAM_END;
  assign inAlias = memReq.addr >= ALIAS_BASE && memReq.addr < ALIAS_END;
  assign flashWord = memReq.addr[16:2];
  assign sramWord = memReq.addr[14:2];
  // byte offset is addr[19:5], so the word is addr[19:7] and bit addr[6:2]
  assign aliasWord = memReq.addr[19:7];
  assign aliasBit = memReq.addr[6:2];
  // 2 KB unit is two 1 KB erase blocks
  assign readAllowed = memReq.fetch || blockReadAllowMask[memReq.addr[16:11]];

  // only flash stalls, so code running from sram keeps going
  assign memReady = !(memReq.valid && inFlash && s.busy);
  assign accept = memReq.valid && memReady;
  assign sramWe = accept && memReq.write && inSram;
  assign aliasWe = accept && memReq.write && inAlias;

  assign cmdWord = flashCmd.addr[16:2];
  assign cmdUnit = flashCmd.addr[16:11];
  assign cmdInRange = flashCmd.addr < FLASH_END;
  assign flashCmdReady = s.state == ST_IDLE;

  always_comb begin
    cmdAllowed = cmdInRange && blockProgramAllowMask[cmdUnit];
    if (flashCmd.op == OP_MASS_ERASE) begin
      cmdAllowed = &blockProgramAllowMask;
    end else if (flashCmd.op != OP_PROGRAM && flashCmd.op != OP_PAGE_ERASE) begin
      // an unknown operation code is refused rather than run with stale settings
      cmdAllowed = 1'b0;
    end
  end

  // program only clears bits; erase fills with ones
  assign flashWrData = (s.op == OP_PROGRAM) ? (flash[s.ptr] & s.data) : '1;
  assign flashWe = s.state == ST_APPLY;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.violation = 1'b0;
    next_s.rsp = '0;
    // bus answer
    if (accept) begin
      next_s.rsp.rvalid = 1'b1;
      if (inSram) begin
        next_s.rsp.rdata = memReq.write ? 32'h0000_0000 : sram[sramWord];
      end else if (inAlias) begin
        next_s.rsp.rdata = memReq.write ? 32'h0000_0000 : {31'h0000_0000, sram[aliasWord][aliasBit]};
      end else if (inFlash && !memReq.write && readAllowed) begin
        next_s.rsp.rdata = flash[flashWord];
      end else begin
        // unmapped, flash write, or data read of execute-only unit
        next_s.rsp.fault = 1'b1;
      end
    end
    // flash sequencer
    unique case (s.state)
      ST_IDLE: begin
        if (flashCmd.valid) begin
          if (cmdAllowed) begin
            next_s.state = ST_WAIT;
            next_s.busy = 1'b1;
            next_s.op = flashCmd.op;
            next_s.data = flashCmd.data;
            unique case (flashCmd.op)
              OP_PROGRAM: begin
                next_s.ptr = cmdWord;
                next_s.last = cmdWord;
                next_s.usLeft = PROGRAM_TIME_US;
              end
              OP_PAGE_ERASE: begin
                next_s.ptr = {cmdWord[14:8], 8'h00};
                next_s.last = {cmdWord[14:8], 8'hff};
                next_s.usLeft = PAGE_ERASE_TIME_US;
              end
              OP_MASS_ERASE: begin
                next_s.ptr = 15'h0000;
                next_s.last = 15'(FLASH_WORDS - 1);
                next_s.usLeft = MASS_ERASE_TIME_US;
              end
            endcase
          end else begin
            next_s.violation = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        if (usTick) begin
          if (s.usLeft == 16'h0001) begin
            next_s.state = ST_APPLY;
          end else begin
            next_s.usLeft = s.usLeft - 16'h0001;
          end
        end
      end
      ST_APPLY: begin
        if (s.ptr == s.last) begin
          next_s.state = ST_IDLE;
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
        end else begin
          next_s.ptr = s.ptr + 15'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '{state: ST_IDLE, op: OP_PROGRAM, ptr: '0, last: '0, data: '0, usLeft: '0,
             busy: 1'b0, done: 1'b0, violation: 1'b0, rsp: '0};
    end else begin
      s <= next_s;
    end
  end

  // arrays carry no reset: flash is nonvolatile, sram contents undefined
  always_ff @(posedge clock) begin
    if (sramWe) begin
      for (int b = 0; b < 4; b++) begin
        if (memReq.byteEnable[b]) begin
          sram[sramWord][8*b +: 8] <= memReq.wdata[8*b +: 8];
        end
      end
    end
    if (aliasWe) begin
      // single-cycle bit write, no master read-modify-write
      sram[aliasWord][aliasBit] <= memReq.wdata[0];
    end
    if (flashWe) begin
      flash[s.ptr] <= flashWrData;
    end
  end

  assign memRsp = s.rsp;
  assign flashBusy = s.busy;
  assign flashDone = s.done;
  assign flashViolation = s.violation;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence cmdTakenOk;
    flashCmd.valid && flashCmdReady && cmdAllowed;
  endsequence
  sequence cmdTakenBad;
    flashCmd.valid && flashCmdReady && !cmdAllowed;
  endsequence
  sequence programApply;
    s.op == OP_PROGRAM && s.state == ST_APPLY;
  endsequence

  a_busy_whole_op: assert property (s.state != ST_IDLE |-> flashBusy)
    else $error("busy low during flash operation");
  a_busy_starts: assert property (cmdTakenOk |=> flashBusy && $rose(flashBusy))
    else $error("busy did not rise on accepted command");
  a_flash_hold_off: assert property (flashBusy && memReq.valid && memReq.addr < FLASH_END |-> !memReady)
    else $error("flash access not held off");
  a_refuse_locked: assert property (cmdTakenBad |=> flashViolation && !flashBusy)
    else $error("protected flash change not refused");
  a_exec_only_read: assert property (accept && inFlash && !memReq.write && !memReq.fetch
                                     && !blockReadAllowMask[memReq.addr[16:11]] |=> memRsp.fault)
    else $error("data read of execute-only unit not faulted");
  a_fetch_allowed: assert property (accept && inFlash && !memReq.write && memReq.fetch |=> !memRsp.fault)
    else $error("fetch refused");
  a_program_clears: assert property (flashWe && s.op == OP_PROGRAM |-> (flashWrData & ~flash[s.ptr]) == 32'h0)
    else $error("program set a bit");
  a_erase_ones: assert property (flashWe && s.op != OP_PROGRAM |-> flashWrData == 32'hffff_ffff)
    else $error("erase wrote a zero");
  a_alias_one_bit: assert property (accept && inAlias && !memReq.write |=> memRsp.rdata[31:1] == 31'h0)
    else $error("alias read wider than one bit");
  a_sram_no_fault: assert property (accept && inSram |=> memRsp.rvalid && !memRsp.fault)
    else $error("sram access faulted");
  a_program_done: assert property (programApply |=> flashDone && !flashBusy)
    else $error("program did not finish after apply");
endmodule // internal_flash_sram_control

// ---- internal_memory_pkg.sv ----
// constants, types and carriers shared by the internal memory block
// assumes a single 200 MHz system clock
package internal_memory_pkg;
  localparam int CLOCK_MHZ = 200;
  localparam logic [7:0] USEC_RELOAD_RESET = 8'(CLOCK_MHZ - 1);
  localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
  localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
  localparam logic [31:0] ALIAS_BASE = 32'h2200_0000;
  localparam int SRAM_BYTES = 32768;
  localparam int FLASH_BYTES = 98304;
  localparam int ALIAS_FACTOR = 32;
  localparam int ERASE_BLOCK_WORDS = 256;
  localparam int PROTECT_UNIT_BYTES = 2048;
  localparam int PROTECT_UNITS = FLASH_BYTES / PROTECT_UNIT_BYTES;
  localparam int FLASH_WORDS = FLASH_BYTES / 4;
  localparam int SRAM_WORDS = SRAM_BYTES / 4;
  // operation times in microseconds, counted on the microsecond tick
  localparam logic [15:0] PROGRAM_TIME_US = 16'h0014;
  localparam logic [15:0] PAGE_ERASE_TIME_US = 16'h0064;
  localparam logic [15:0] MASS_ERASE_TIME_US = 16'h00c8;

  typedef enum logic [2:0] {
    OP_PROGRAM = 3'b001,
    OP_PAGE_ERASE = 3'b010,
    OP_MASS_ERASE = 3'b100
  } flash_op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_APPLY = 3'b100
  } flash_state_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic fetch;
    logic [3:0] byteEnable;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_s;

  typedef struct packed {
    logic rvalid;
    logic fault;
    logic [31:0] rdata;
  } mem_rsp_s;

  typedef struct packed {
    logic valid;
    flash_op_e op;
    logic [31:0] addr;
    logic [31:0] data;
  } flash_cmd_s;
endpackage

// ---- microsecond_tick.sv ----
// microsecond enable divider for flash timing
// assumes software keeps the reload equal to clock MHz minus one
`timescale 1ns/10ps
module microsecond_tick (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // reload update
  input wire logic reloadWrite,
  input wire logic [7:0] reloadValue,
  // outputs
  output logic [7:0] microsecondCycleReload,
  output logic usTick
);
  import internal_memory_pkg::*;

  typedef struct packed {
    logic [7:0] reload;
    logic [7:0] count;
    logic tick;
  } tick_state_s;

  tick_state_s s, next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (reloadWrite) begin
      next_s.reload = reloadValue;
      next_s.count = reloadValue;
    end else if (s.count == 8'h00) begin
      next_s.count = s.reload;
      next_s.tick = 1'b1;
    end else begin
      next_s.count = s.count - 8'h01;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '{reload: USEC_RELOAD_RESET, count: USEC_RELOAD_RESET, tick: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign microsecondCycleReload = s.reload;
  assign usTick = s.tick;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // period is reload plus one cycles; checked at the reload of three that the tick scale run uses
  a_tick_spacing: assert property ((usTick && !reloadWrite && s.reload == 8'h03) ##1 (!reloadWrite) [*3] |-> ##1 usTick)
    else $error("microsecond tick spacing wrong");
  a_tick_single: assert property (usTick && s.reload != 8'h00 |=> !usTick)
    else $error("microsecond tick longer than one cycle");
endmodule // microsecond_tick

// ---- bus_master_model.sv ----
// bus master standing for the processor core and the debugger
// assumes a request is taken on the edge where memReady is high
`timescale 1ns/10ps
module bus_master_model (
  // clock
  input wire logic clock,
  // memory bus
  output internal_memory_pkg::mem_req_s memReq,
  input wire logic memReady,
  input internal_memory_pkg::mem_rsp_s memRsp
);
  import internal_memory_pkg::*;
  initial memReq = '0;
  // released fields other than byteEnable are inverted so a stale value never passes for a fresh one
  task automatic access(input logic write, input logic fetch, input logic [3:0] be, input logic [31:0] addr,
      input logic [31:0] wdata, output mem_rsp_s rsp, output int waits);
    waits = 0;
    @(posedge clock);
    #1;
    memReq = '{valid: 1'b1, write: write, fetch: fetch, byteEnable: be, addr: addr, wdata: wdata};
    #1;
    while (memReady !== 1'b1 && waits < 40000) begin
      @(posedge clock);
      #1;
      waits++;
    end
    @(posedge clock);
    #1;
    rsp = memRsp;
    memReq = '{valid: 1'b0, write: ~write, fetch: ~fetch, byteEnable: 4'h0, addr: ~addr, wdata: ~wdata};
  endtask
endmodule // bus_master_model

// ---- testbench.sv ----
// self-checking bench of the internal sram and flash block
// assumes the tick is shortened to every cycle by a reload of zero
`timescale 1ns/10ps
module testbench;
  import internal_memory_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  internal_memory_pkg::mem_req_s memReq;
  internal_memory_pkg::mem_rsp_s memRsp;
  mem_rsp_s rsp;
  logic memReady, flashCmdReady, flashBusy, flashDone, flashViolation, viol;
  logic reloadWrite = 1'b0;
  logic [7:0] reloadValue = 8'h00;
  logic [7:0] microsecondCycleReload;
  flash_cmd_s flashCmd = '0;
  logic [PROTECT_UNITS-1:0] blockProgramAllowMask = '1;
  logic [PROTECT_UNITS-1:0] blockReadAllowMask = '1;
  int mismatches = 0;
  int samplesChecked = 0;
  int waits, n0, n3;
  always #2.5 clock = ~clock;
  internal_flash_sram_control i_dut (.clock(clock), .rst(rst), .memReq(memReq), .memReady(memReady),
    .memRsp(memRsp), .flashCmd(flashCmd), .flashCmdReady(flashCmdReady), .flashBusy(flashBusy),
    .flashDone(flashDone), .flashViolation(flashViolation), .reloadWrite(reloadWrite),
    .reloadValue(reloadValue), .microsecondCycleReload(microsecondCycleReload),
    .blockProgramAllowMask(blockProgramAllowMask), .blockReadAllowMask(blockReadAllowMask));
  bus_master_model i_master (.clock(clock), .memReq(memReq), .memReady(memReady), .memRsp(memRsp));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samplesChecked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d checked %0d", mismatches, samplesChecked);
    if (mismatches == 0 && samplesChecked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic rd(input logic fetch, input logic [31:0] addr, input logic [31:0] exp, input logic fault);
    i_master.access(1'b0, fetch, 4'hf, addr, 32'h0, rsp, waits);
    check("read wait limit", 32'h1, waits < 40000);
    check("rvalid", 32'h1, rsp.rvalid);
    check("rdata", exp, rsp.rdata);
    check("fault", fault, rsp.fault);
  endtask
  task automatic wr(input logic [31:0] addr, input logic [31:0] data, input logic [3:0] be);
    i_master.access(1'b1, 1'b0, be, addr, data, rsp, waits);
    check("write wait limit", 32'h1, waits < 40000);
    check("write rvalid", 32'h1, rsp.rvalid);
    check("write rdata", 32'h0, rsp.rdata);
  endtask
  // software duty: reload is clock MHz minus one before any change
  task automatic reload(input logic [7:0] v);
    @(posedge clock);
    #1;
    reloadWrite = 1'b1;
    reloadValue = v;
    @(posedge clock);
    #1;
    reloadWrite = 1'b0;
    check("reload", v, microsecondCycleReload);
  endtask
  task automatic cmd(input flash_op_e op, input logic [31:0] addr, input logic [31:0] data, output int n);
    n = 0;
    @(posedge clock);
    #1;
    flashCmd = '{valid: 1'b1, op: op, addr: addr, data: data};
    @(posedge clock);
    #1;
    flashCmd = '{valid: 1'b0, op: op, addr: ~addr, data: ~data};
    viol = flashViolation;
    check("cmd ready while busy", viol, flashCmdReady);
    @(posedge clock);
    #1;
    viol |= flashViolation;
    while (flashBusy === 1'b1 && n < 30000) begin
      @(posedge clock);
      #1;
      n++;
    end
    check("busy ended", 32'h0, flashBusy);
    check("done", !viol, flashDone);
  endtask
  task automatic sramAlias;
    wr(SRAM_BASE + 32'h1000, 32'h0000_00f0, 4'hf);
    // alias write ignores byte enables, so none are given
    wr(ALIAS_BASE + 32'h2_000c, 32'h1, 4'h0);
    rd(1'b0, SRAM_BASE + 32'h1000, 32'h0000_00f8, 1'b0);
    wr(ALIAS_BASE + 32'h2_0010, 32'h0, 4'hf);
    rd(1'b0, ALIAS_BASE + 32'h2_0010, 32'h0, 1'b0);
    rd(1'b0, ALIAS_BASE + 32'h2_0014, 32'h1, 1'b0);
    rd(1'b0, SRAM_BASE + 32'h1000, 32'h0000_00e8, 1'b0);
    wr(SRAM_BASE + 32'h7ffc, 32'h5a5a_c3c3, 4'hf);
    rd(1'b0, SRAM_BASE + 32'h7ffc, 32'h5a5a_c3c3, 1'b0);
    wr(SRAM_BASE + 32'h7ffc, 32'h1111_2222, 4'h2);
    rd(1'b0, SRAM_BASE + 32'h7ffc, 32'h5a5a_22c3, 1'b0);
    rd(1'b0, SRAM_BASE + 32'h8000, 32'h0, 1'b1);
  endtask
  task automatic flashOps;
    reload(8'h00);
    cmd(OP_PAGE_ERASE, FLASH_BASE, 32'h0, n0);
    // busy spans the wait plus one cycle per word; the count misses the first busy cycle
    check("erase time", PAGE_ERASE_TIME_US + ERASE_BLOCK_WORDS - 1, n0);
    rd(1'b0, 32'h3fc, 32'hffff_ffff, 1'b0);
    cmd(OP_PROGRAM, 32'h4, 32'h1234_abcd, n0);
    check("program time", PROGRAM_TIME_US, n0);
    // the fetch is issued while the program runs and must stall
    fork
      cmd(OP_PROGRAM, 32'h4, 32'hffff_00ff, n0);
      begin
        @(posedge clock);
        rd(1'b1, 32'h8, 32'hffff_ffff, 1'b0);
      end
    join
    check("stall", 32'h1, waits >= PROGRAM_TIME_US);
    rd(1'b0, 32'h4, 32'h1234_00cd, 1'b0);
    reload(8'h03);
    cmd(OP_PROGRAM, 32'hc, 32'h0, n3);
    check("tick scale", 32'h1, n3 - n0 >= 54 && n3 - n0 <= 66);
    reload(8'h00);
  endtask
  task automatic protect;
    blockReadAllowMask[0] = 1'b0;
    rd(1'b0, 32'h4, 32'h0, 1'b1);
    rd(1'b1, 32'h4, 32'h1234_00cd, 1'b0);
    blockProgramAllowMask[1] = 1'b0;
    cmd(OP_PROGRAM, 32'h800, 32'h0, n0);
    check("unit 1 refused", 32'h1, viol);
    cmd(OP_PAGE_ERASE, 32'h7fc, 32'h0, n0);
    check("unit 0 taken", 32'h0, viol);
    cmd(OP_MASS_ERASE, 32'h0, 32'h0, n0);
    check("mass refused", 32'h1, viol);
    blockProgramAllowMask[1] = 1'b1;
    cmd(OP_PROGRAM, 32'h1_8000, 32'h0, n0);
    check("beyond flash", 32'h1, viol);
    cmd(OP_MASS_ERASE, 32'h0, 32'h0, n0);
    check("mass taken", 32'h0, viol);
    blockReadAllowMask[0] = 1'b1;
    rd(1'b0, 32'hc, 32'hffff_ffff, 1'b0);
  endtask
  // the whole run needs about 26000 cycles; the watchdog allows 80000
  initial begin
    #400000;
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge clock);
    #1;
    rst = 1'b0;
    check("reset reload", 32'h0000_00c7, microsecondCycleReload);
    check("cmd ready", 32'h1, flashCmdReady);
    sramAlias();
    flashOps();
    protect();
    end_sim();
  end
endmodule // testbench
